// ===== ipi_top.sv
// interrupt pin front end and initialization status output
`timescale 1ns/10ps
`default_nettype none
module ipi_top
    import ipi_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic agent_msg_or_irq0_n_in,
    input wire logic irq_line_1_n_in,
    input wire logic irq2_or_ext_request_n_in,
    input wire logic irq3_or_ack_n_in,
    input wire logic async_mode_in,
    input wire logic line0_msg_mode_in,
    input wire logic line2_ext_mode_in,
    input wire logic line3_ack_mode_in,
    input wire logic ack_request_in,
    input wire logic data_cycle_state_in,
    input wire logic selftest_done_in,
    input wire logic selftest_pass_in,
    input wire logic word_valid_in,
    input wire logic [31:0] word_in,
    output logic irq3_or_ack_out,
    output logic irq3_or_ack_oe_n_out,
    output logic selftest_error_flag_n_out,
    output logic selftest_error_flag_oe_n_out,
    output logic word_req_out,
    output logic [3:0] word_index_out,
    output logic init_go_out,
    output logic agent_message_request_out,
    output logic [3:0] irq_request_out,
    output logic ext_controller_request_out
);
    typedef struct packed {
        logic ack_latch;
        logic ack_oe_n;
        logic flag_oe_n;
        logic msg_req;
        logic [3:0] irq_req;
        logic ext_req;
    } ipi_top_t;

    ipi_top_t st;
    ipi_top_t next_st;
    logic [3:0] line_n;
    logic [3:0] line_en;
    logic [3:0] line_hit;
    logic flag_raw;

    assign line_n = {irq3_or_ack_n_in, irq2_or_ext_request_n_in,
                     irq_line_1_n_in, agent_msg_or_irq0_n_in};
    // line 3 stops sensing while it is the acknowledge output
    assign line_en = {~line3_ack_mode_in, 3'h7};

    // per-line synchroniser and qualifier
    genvar gi;
    generate
        for (gi = 0; gi < IPI_NUM_LINES; gi++) begin : g_line
            ipi_line_detect u_det (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .line_n_in(line_n[gi]),
                .async_mode_in(async_mode_in),
                .enable_in(line_en[gi]),
                .request_out(line_hit[gi])
            );
        end
    endgenerate

    ipi_init_check u_init (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .selftest_done_in(selftest_done_in),
        .selftest_pass_in(selftest_pass_in),
        .word_valid_in(word_valid_in),
        .word_in(word_in),
        .word_req_out(word_req_out),
        .word_index_out(word_index_out),
        .flag_out(flag_raw),
        .init_go_out(init_go_out)
    );

    // route detections by mode, drive open-drain outputs
    always_comb begin
        next_st = st;
        next_st.msg_req = line_hit[0] & line0_msg_mode_in;
        next_st.irq_req[0] = line_hit[0] & ~line0_msg_mode_in;
        next_st.irq_req[1] = line_hit[1];
        next_st.irq_req[2] = line_hit[2] & ~line2_ext_mode_in;
        next_st.ext_req = line_hit[2] & line2_ext_mode_in;
        next_st.irq_req[3] = line_hit[3] & ~line3_ack_mode_in;
        // hold acknowledge steady through data cycles
        if (!data_cycle_state_in) begin
            next_st.ack_latch = ack_request_in & line3_ack_mode_in;
        end
        if (!line3_ack_mode_in) begin
            next_st.ack_latch = 1'b0;
        end
        next_st.ack_oe_n = ~next_st.ack_latch;
        next_st.flag_oe_n = ~flag_raw;
    end

    // state register; enables kept in pin polarity so outputs leave flops directly
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            st <= '{ack_latch: 1'b0, ack_oe_n: 1'b1, flag_oe_n: 1'b1, msg_req: 1'b0,
                    irq_req: 4'h0, ext_req: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign irq3_or_ack_out = 1'b0; // open drain pulls low only
    assign irq3_or_ack_oe_n_out = st.ack_oe_n;
    assign selftest_error_flag_n_out = 1'b0;
    assign selftest_error_flag_oe_n_out = st.flag_oe_n;
    assign agent_message_request_out = st.msg_req;
    assign irq_request_out = st.irq_req;
    assign ext_controller_request_out = st.ext_req;
endmodule
`default_nettype wire

// ===== ipi_pkg.sv
// shared constants and types for the interrupt pin and init status block
package ipi_pkg;
    localparam int IPI_NUM_LINES = 4;
    localparam int IPI_CHECK_WORDS = 8; // words summed by the memory checksum
    localparam logic [3:0] IPI_CHECK_LAST = 4'h7; // index of the last summed word
    localparam logic [1:0] IPI_SYNC_INACT_CYC = 2'h1; // inactive bus cycles, synchronous
    localparam logic [1:0] IPI_SYNC_ACT_CYC = 2'h1; // active bus cycles, synchronous
    localparam logic [1:0] IPI_ASYNC_INACT_CYC = 2'h2; // inactive bus cycles, asynchronous
    localparam logic [1:0] IPI_ASYNC_ACT_CYC = 2'h2; // active bus cycles, asynchronous
    localparam logic [1:0] IPI_CNT_RESET = 2'h0;
    localparam logic [2:0] IPI_SYNC_RESET = 3'h7; // lines idle high
    localparam logic [31:0] IPI_SUM_RESET = 32'h0000_0000;

    typedef enum logic [4:0] {
        IPI_ST_IDLE = 5'h01,
        IPI_ST_TEST = 5'h02,
        IPI_ST_CHECK = 5'h04,
        IPI_ST_RUN = 5'h08,
        IPI_ST_FAIL = 5'h10
    } ipi_state_t;
endpackage

// ===== ipi_line_detect.sv
// one interrupt line: three-stage synchroniser and inactive/active qualifier
`timescale 1ns/10ps
`default_nettype none
module ipi_line_detect
    import ipi_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic line_n_in,
    input wire logic async_mode_in,
    input wire logic enable_in,
    output logic request_out
);
    typedef struct packed {
        logic [2:0] sync;
        logic armed;
        logic [1:0] inact_cnt;
        logic [1:0] act_cnt;
        logic request;
    } ipi_ld_t;

    ipi_ld_t st;
    ipi_ld_t next_st;
    logic [1:0] need_inact;
    logic [1:0] need_act;
    logic level_low;
    logic level_high;

    // required inactive and active periods per system kind
    assign need_inact = async_mode_in ? IPI_ASYNC_INACT_CYC : IPI_SYNC_INACT_CYC;
    assign need_act = async_mode_in ? IPI_ASYNC_ACT_CYC : IPI_SYNC_ACT_CYC;
    // stages two and three must agree before a level counts
    assign level_low = ~st.sync[1] & ~st.sync[2];
    assign level_high = st.sync[1] & st.sync[2];

    // qualifier: inactive period arms, active period then fires once
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[1:0], line_n_in};
        next_st.request = 1'b0;
        if (!enable_in) begin
            next_st.armed = 1'b0;
            next_st.inact_cnt = IPI_CNT_RESET;
            next_st.act_cnt = IPI_CNT_RESET;
        end else if (level_high) begin
            next_st.act_cnt = IPI_CNT_RESET;
            if (st.inact_cnt < need_inact) begin
                next_st.inact_cnt = st.inact_cnt + 2'h1;
            end
            if (st.inact_cnt + 2'h1 >= need_inact) begin
                next_st.armed = 1'b1;
            end
        end else if (level_low) begin
            next_st.inact_cnt = IPI_CNT_RESET;
            if (st.armed) begin
                if (st.act_cnt + 2'h1 >= need_act) begin
                    next_st.request = 1'b1;
                    next_st.armed = 1'b0;
                    next_st.act_cnt = IPI_CNT_RESET;
                end else begin
                    next_st.act_cnt = st.act_cnt + 2'h1;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            st <= '{sync: IPI_SYNC_RESET, armed: 1'b0, inact_cnt: IPI_CNT_RESET,
                    act_cnt: IPI_CNT_RESET, request: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign request_out = st.request;
endmodule
`default_nettype wire

// ===== ipi_init_check.sv
// self-test and zero checksum over the first memory words
`timescale 1ns/10ps
`default_nettype none
module ipi_init_check
    import ipi_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic selftest_done_in,
    input wire logic selftest_pass_in,
    input wire logic word_valid_in,
    input wire logic [31:0] word_in,
    output logic word_req_out,
    output logic [3:0] word_index_out,
    output logic flag_out,
    output logic init_go_out
);
    typedef struct packed {
        ipi_state_t state;
        logic [3:0] index;
        logic [31:0] sum;
        logic flag;
        logic go;
        logic req;
    } ipi_ic_t;

    ipi_ic_t st;
    ipi_ic_t next_st;
    logic [31:0] new_sum;

    assign new_sum = st.sum + word_in;

    // init sequence: test, check, then run or fail forever
    always_comb begin
        next_st = st;
        next_st.req = 1'b0;
        unique case (st.state)
            IPI_ST_IDLE: begin
                next_st.state = IPI_ST_TEST;
                next_st.flag = 1'b1;
            end
            IPI_ST_TEST: begin
                if (selftest_done_in) begin
                    if (selftest_pass_in) begin
                        next_st.flag = 1'b0;
                        next_st.state = IPI_ST_CHECK;
                        next_st.req = 1'b1;
                    end else begin
                        next_st.state = IPI_ST_FAIL;
                    end
                end
            end
            IPI_ST_CHECK: begin
                next_st.req = 1'b1;
                if (word_valid_in) begin
                    next_st.sum = new_sum;
                    next_st.index = st.index + 4'h1;
                    if (st.index == IPI_CHECK_LAST) begin
                        next_st.req = 1'b0;
                        if (new_sum != IPI_SUM_RESET) begin
                            next_st.state = IPI_ST_FAIL;
                            next_st.flag = 1'b1;
                        end else begin
                            next_st.state = IPI_ST_RUN;
                            next_st.go = 1'b1;
                        end
                    end
                end
            end
            IPI_ST_RUN: begin
                next_st.flag = 1'b0;
            end
            IPI_ST_FAIL: begin
                next_st.flag = 1'b1;
            end
            default: begin
                next_st.state = IPI_ST_FAIL;
                next_st.flag = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            st <= '{state: IPI_ST_IDLE, index: 4'h0, sum: IPI_SUM_RESET,
                    flag: 1'b0, go: 1'b0, req: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign word_req_out = st.req;
    assign word_index_out = st.index;
    assign flag_out = st.flag;
    assign init_go_out = st.go;
endmodule
`default_nettype wire

// ===== ipi_chk.sv
// port-level assertions for the interrupt pin and init status block
`timescale 1ns/10ps
`default_nettype none
module ipi_chk
    import ipi_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic irq_line_1_n_in,
    input wire logic async_mode_in,
    input wire logic line0_msg_mode_in,
    input wire logic line3_ack_mode_in,
    input wire logic ack_request_in,
    input wire logic data_cycle_state_in,
    input wire logic word_valid_in,
    input wire logic irq3_or_ack_oe_n_out,
    input wire logic selftest_error_flag_oe_n_out,
    input wire logic word_req_out,
    input wire logic [3:0] word_index_out,
    input wire logic init_go_out,
    input wire logic agent_message_request_out,
    input wire logic [3:0] irq_request_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // status flag and checksum walk
    flag_test_a: assert property (
        $rose(resetn_in) |-> ##[1:3] !selftest_error_flag_oe_n_out) else $error("flag late");
    flag_hold_a: assert property (
        $fell(selftest_error_flag_oe_n_out) |=> (!selftest_error_flag_oe_n_out) [*8])
        else $error("flag not held");
    index_step_a: assert property (
        word_req_out && word_valid_in && word_index_out != IPI_CHECK_LAST
        |=> word_index_out == $past(word_index_out) + 4'h1) else $error("word index stuck");
    go_clean_a: assert property (
        init_go_out |-> selftest_error_flag_oe_n_out ##1 init_go_out) else $error("go with flag");
    // line 0 meaning follows its mode bit
    msg_mode_a: assert property (
        $stable(line0_msg_mode_in) [*6] |-> (line0_msg_mode_in ? !irq_request_out[0]
        : !agent_message_request_out)) else $error("line 0 wrong meaning");
    // qualified request timing on line 1
    line_answer_a: assert property (
        (!async_mode_in && irq_line_1_n_in) [*3] ##1 (!irq_line_1_n_in) [*2]
        |-> ##[1:6] irq_request_out[1]) else $error("line 1 request lost");
    sync_delay_a: assert property (
        $fell(irq_line_1_n_in) |-> (!irq_request_out[1]) [*3]) else $error("line 1 too early");
    // acknowledge output latch
    ack_follow_a: assert property (
        (line3_ack_mode_in && !data_cycle_state_in) [*3]
        |-> irq3_or_ack_oe_n_out == !$past(ack_request_in, 1)) else $error("ack not following");
    ack_hold_a: assert property (
        (line3_ack_mode_in && data_cycle_state_in) [*3] |-> $stable(irq3_or_ack_oe_n_out))
        else $error("ack moved in data cycle");

    cover property (init_go_out);
    cover property (agent_message_request_out);
    cover property (!irq3_or_ack_oe_n_out);
endmodule
bind ipi_top ipi_chk chk_u (.*);
`default_nettype wire

// ===== ipi_far_model.sv
// far-side model: interrupt sources and the first memory words
`timescale 1ns/10ps
`default_nettype none
module ipi_far_model
    import ipi_pkg::*;
(
    input wire logic clk_in,
    input wire logic bad_sum_in,
    input wire logic word_req_in,
    input wire logic [3:0] word_index_in,
    output logic [3:0] line_n_out,
    output logic word_valid_out,
    output logic [31:0] word_out
);
    // pulled-up idle lines, high through reset too
    initial begin
        line_n_out = 4'hF;
        word_valid_out = 1'b0;
        word_out = 32'h0000_0000;
    end

    // inactive then active for n cycles each, then released
    task automatic fire(input int i, input int n);
        repeat (n) @(negedge clk_in);
        line_n_out[i] = 1'b0;
        repeat (n) @(negedge clk_in);
        line_n_out[i] = 1'b1;
    endtask

    // words 1..7, last cancels the sum unless a bad sum is asked for
    always @(negedge clk_in) begin
        word_valid_out <= word_req_in && !word_valid_out;
        if (word_req_in && !word_valid_out) begin
            word_out <= (word_index_in == IPI_CHECK_LAST) ?
                (bad_sum_in ? 32'h0000_0000 : 32'hFFFF_FFE4) : {28'h0, word_index_in} + 32'h1;
        end else begin
            word_out <= ~word_out; // no stale word while idle
        end
    end
endmodule
`default_nettype wire

// ===== tb_irq_pins_and_init_status.sv
// self-checking bench for the interrupt pin and init status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module tb_irq_pins_and_init_status;
    import ipi_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, bad_sum = 1'b0;
    logic async_mode_in = 1'b0, line0_msg_mode_in = 1'b0, line2_ext_mode_in = 1'b0;
    logic line3_ack_mode_in = 1'b0, ack_request_in = 1'b0, data_cycle_state_in = 1'b0;
    logic selftest_done_in = 1'b0, selftest_pass_in = 1'b0, word_valid_in;
    logic irq3_or_ack_out, irq3_or_ack_oe_n_out, selftest_error_flag_n_out, word_req_out;
    logic selftest_error_flag_oe_n_out, init_go_out, agent_message_request_out;
    logic ext_controller_request_out;
    logic [3:0] word_index_out, irq_request_out, line_n;
    logic [31:0] word_in;
    wire logic agent_msg_or_irq0_n_in, irq_line_1_n_in, irq2_or_ext_request_n_in;
    wire logic irq3_or_ack_n_in;
    int cnt [6];
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    assign agent_msg_or_irq0_n_in = line_n[0];
    assign irq_line_1_n_in = line_n[1];
    assign irq2_or_ext_request_n_in = line_n[2];
    // open-drain line 3: low when the source or the block pulls it
    assign irq3_or_ack_n_in = line_n[3] & (irq3_or_ack_oe_n_out !== 1'b0);

    ipi_top dut_u (.*);
    ipi_far_model far_u (.clk_in(clk_in), .bad_sum_in(bad_sum), .word_req_in(word_req_out),
        .word_index_in(word_index_out), .line_n_out(line_n), .word_valid_out(word_valid_in),
        .word_out(word_in));

    always #10 clk_in = ~clk_in;

    // pulse counters and hang guard
    always @(posedge clk_in) begin
        for (int b = 0; b < 4; b++) cnt[b] += int'(irq_request_out[b]);
        cnt[4] += int'(agent_message_request_out);
        cnt[5] += int'(ext_controller_request_out);
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // self-test and checksum outcome on the status flag
    task automatic t_init(input logic pass, input logic bad);
        bad_sum = bad;
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (10) @(negedge clk_in);
        `CHK("flag in test", 1'b0, selftest_error_flag_oe_n_out)
        `CHK("flag level", 1'b0, selftest_error_flag_n_out)
        selftest_pass_in = pass;
        selftest_done_in = 1'b1;
        @(negedge clk_in);
        selftest_done_in = 1'b0;
        repeat (3) @(negedge clk_in);
        `CHK("flag after test", pass, selftest_error_flag_oe_n_out)
        for (int k = 0; k < 40 && word_req_out === 1'b1; k++) @(negedge clk_in);
        repeat (3) @(negedge clk_in);
        `CHK("init go", pass & !bad, init_go_out)
        `CHK("flag after sum", pass & !bad, selftest_error_flag_oe_n_out)
    endtask

    // one request on line i, then which outputs pulsed exactly once
    task automatic t_irq(input int i, input int n, input logic [5:0] exp);
        logic [5:0] got;
        for (int b = 0; b < 6; b++) cnt[b] = 0;
        far_u.fire(i, n);
        repeat (12) @(negedge clk_in);
        for (int b = 0; b < 6; b++) got[b] = (cnt[b] == 1);
        `CHK("pulse map", exp, got)
    endtask

    // acknowledge follows its request and freezes in data cycles
    task automatic t_ack();
        ack_request_in = 1'b1;
        repeat (3) @(negedge clk_in);
        `CHK("ack on", 1'b0, irq3_or_ack_n_in)
        `CHK("ack level", 1'b0, irq3_or_ack_out)
        data_cycle_state_in = 1'b1;
        ack_request_in = 1'b0;
        repeat (3) @(negedge clk_in);
        `CHK("ack held", 1'b0, irq3_or_ack_n_in)
        data_cycle_state_in = 1'b0;
        repeat (3) @(negedge clk_in);
        `CHK("ack off", 1'b1, irq3_or_ack_n_in)
    endtask

    initial begin
        t_init(1'b1, 1'b1);
        t_init(1'b0, 1'b0);
        t_init(1'b1, 1'b0);
        t_irq(0, 2, 6'h01);
        t_irq(1, 2, 6'h02);
        t_irq(2, 2, 6'h04);
        t_irq(3, 2, 6'h08);
        line0_msg_mode_in = 1'b1;
        line2_ext_mode_in = 1'b1;
        line3_ack_mode_in = 1'b1;
        repeat (8) @(negedge clk_in);
        t_irq(0, 2, 6'h10);
        t_irq(2, 2, 6'h20);
        t_irq(3, 2, 6'h00);
        t_ack();
        async_mode_in = 1'b1;
        repeat (8) @(negedge clk_in);
        t_irq(1, 2, 6'h00);
        t_irq(1, 3, 6'h02);
        print_verdict();
    end
endmodule
`default_nettype wire
